// ### common/pwm_map.vh
// register map, field positions and reset values of the match based pwm timer
`ifndef PWM_MAP_VH
`define PWM_MAP_VH

// byte offsets on the register bus
`define A_CTRL       8'h00
`define A_COUNT      8'h04
`define A_PRESC      8'h08
`define A_PCOUNT     8'h0C
`define A_MCTL       8'h10
`define A_FLAGS      8'h14
`define A_PWMCTL     8'h18
`define A_LATCH      8'h1C
`define A_MATCH0     8'h20
`define A_MATCH6     8'h38

// control register fields
`define CTRL_RUN     0
`define CTRL_CRST    1
`define CTRL_PWM     3
`define CTRL_MASK    32'h0000000B

// match control: three bits per match register
`define MCTL_INT     0
`define MCTL_RST     1
`define MCTL_STOP    2
`define MCTL_MASK    32'h001FFFFF

// pwm control: double edge select bits 6:2, output enables bits 14:9
`define PSEL_LO      2
`define PENA_LO      9
`define PWMCTL_MASK  32'h00007E7C

// number of match registers and pwm outputs
`define N_MATCH      7
`define N_OUT        6

`define RST_WORD     32'h00000000
`define RESP_OK      2'b00
`define RESP_SLVERR  2'b10

`endif

// ### logic/prescaled_counter.v
// prescaler and 32-bit timer counter of the match based pwm timer
`include "pwm_map.vh"

module prescaled_counter (
    input  wire        clk,        // system clock
    input  wire        rst_s_n,    // synchronised reset, active low
    input  wire        run,        // counting enabled
    input  wire        hold_clr,   // hold prescaler and counter at zero
    input  wire [31:0] presc_term, // prescaler terminal value
    input  wire        tick_clr,   // on this tick load zero instead of adding one
    output reg  [31:0] count,      // timer counter
    output reg  [31:0] pcount,     // prescaler count
    output wire        tick        // counter advances at this edge
);

    assign tick = run && !hold_clr && (pcount == presc_term);

    // ==================================================
    // prescaler and counter
    always @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            count  <= `RST_WORD;
            pcount <= `RST_WORD;
        end
        else if (hold_clr)
        begin
            count  <= `RST_WORD;
            pcount <= `RST_WORD;
        end
        else if (tick)
        begin
            pcount <= `RST_WORD;
            count  <= tick_clr ? `RST_WORD : count + 32'h00000001;
        end
        else if (run)
        begin
            pcount <= pcount + 32'h00000001;
        end
    end

endmodule

// ### logic/match_based_pwm_timer.v
// match based pwm timer with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "pwm_map.vh"

// What this block does
// - 32-bit counter behind 32-bit prescaler
// - seven match registers, six outputs
// - period match resets the counter
// - single edge output uses one match
// - single edge outputs rise at period
// - double edge output uses two matches
// - edge order gives positive or negative pulse
// - per match: continue, stop, reset, flag
// - in pwm mode, released match updates applied at period boundary
// - timer only when pwm mode off
// - any count for period and width
module match_based_pwm_timer (
    input  wire        clk,     // 50 MHz system clock
    input  wire        rst_n,   // asynchronous reset, active low
    input  wire [7:0]  awaddr,  // write address
    input  wire        awvalid, // write address valid
    output reg         awready, // write address ready
    input  wire [31:0] wdata,   // write data
    input  wire [3:0]  wstrb,   // write byte strobes
    input  wire        wvalid,  // write data valid
    output reg         wready,  // write data ready
    output reg  [1:0]  bresp,   // write response
    output reg         bvalid,  // write response valid
    input  wire        bready,  // write response ready
    input  wire [7:0]  araddr,  // read address
    input  wire        arvalid, // read address valid
    output reg         arready, // read address ready
    output reg  [31:0] rdata,   // read data
    output reg  [1:0]  rresp,   // read response
    output reg         rvalid,  // read data valid
    input  wire        rready,  // read data ready
    output reg  [5:0]  pwm_out  // modulated outputs 1 to 6
);

    // ==================================================
    // reset synchroniser
    reg rst_meta_n;
    reg rst_s_n;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_s_n    <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_s_n    <= rst_meta_n;
        end
    end

    // ==================================================
    // registers and state
    reg  [31:0] ctrl;
    reg  [31:0] presc;
    reg  [31:0] mctl;
    reg  [6:0]  flags;
    reg  [31:0] pwmctl;
    reg  [6:0]  latch;
    reg  [31:0] shadow [0:6];
    reg  [31:0] active [0:6];
    wire [31:0] count;
    wire [31:0] pcount;
    wire        tick;
    wire [6:0]  hit;
    wire [6:0]  rst_bits;
    wire [6:0]  stop_bits;
    wire [6:0]  int_bits;
    wire        pwm_en;
    wire        period_evt;
    wire        tick_clr;
    wire [6:0]  applied;

    assign pwm_en = ctrl[`CTRL_PWM];

    // ==================================================
    // per match compare
    genvar g;
    generate
        for (g = 0; g < `N_MATCH; g = g + 1)
        begin : match_cmp
            assign hit[g]       = tick && (count == active[g]);
            assign int_bits[g]  = mctl[3 * g + `MCTL_INT];
            assign rst_bits[g]  = mctl[3 * g + `MCTL_RST];
            assign stop_bits[g] = mctl[3 * g + `MCTL_STOP];
        end
    endgenerate

    // period match always resets in pwm mode
    assign period_evt = hit[0];
    assign tick_clr   = |(hit & rst_bits) || (pwm_en && period_evt);
    // released values move at period match
    assign applied    = (pwm_en && period_evt) ? latch : 7'h00;

    prescaled_counter i_prescaled_counter (
        .clk        (clk),
        .rst_s_n    (rst_s_n),
        .run        (ctrl[`CTRL_RUN]),
        .hold_clr   (ctrl[`CTRL_CRST]),
        .presc_term (presc),
        .tick_clr   (tick_clr),
        .count      (count),
        .pcount     (pcount),
        .tick       (tick)
    );

    // ==================================================
    // bus write channel
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  wa;
    reg  [31:0] wd;
    reg  [3:0]  ws;
    wire        do_write;
    wire        wr_match;
    wire [2:0]  wr_idx;
    wire        wr_known;

    assign do_write = aw_held && w_held && !bvalid;
    assign wr_idx   = wa[4:2];
    assign wr_match = (wa[7:5] == 3'h1) && (wr_idx != 3'h7);
    assign wr_known = wr_match || (wa[7:2] <= `A_LATCH >> 2);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge[8 * b +: 8] = data[8 * b +: 8];
        end
    endfunction

    function wr_at;
        input [7:0] a;
        begin
            wr_at = do_write && (wa[7:2] == a[7:2]);
        end
    endfunction

    always @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wa      <= 8'h00;
            wd      <= `RST_WORD;
            ws      <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OK;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wa      <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wd     <= wdata;
                ws     <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_known ? `RESP_OK : `RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ==================================================
    // register updates
    integer i;

    always @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            ctrl   <= `RST_WORD;
            presc  <= `RST_WORD;
            mctl   <= `RST_WORD;
            flags  <= 7'h00;
            pwmctl <= `RST_WORD;
            latch  <= 7'h00;
            for (i = 0; i < `N_MATCH; i = i + 1)
            begin
                shadow[i] <= `RST_WORD;
                active[i] <= `RST_WORD;
            end
        end
        else
        begin
            if (wr_at(`A_CTRL))
                ctrl <= merge(ctrl, wd, ws) & `CTRL_MASK;
            if (|(hit & stop_bits))
                ctrl[`CTRL_RUN] <= 1'b0;
            if (wr_at(`A_PRESC))
                presc <= merge(presc, wd, ws);
            if (wr_at(`A_MCTL))
                mctl <= merge(mctl, wd, ws) & `MCTL_MASK;
            if (wr_at(`A_PWMCTL))
                pwmctl <= merge(pwmctl, wd, ws) & `PWMCTL_MASK;
            // match flag, set wins over clear
            if (wr_at(`A_FLAGS) && ws[0])
                flags <= (flags & ~wd[6:0]) | (hit & int_bits);
            else
                flags <= flags | (hit & int_bits);
            // release bits, a new release wins
            if (wr_at(`A_LATCH) && ws[0])
                latch <= (latch & ~applied) | wd[6:0];
            else
                latch <= latch & ~applied;
            for (i = 0; i < `N_MATCH; i = i + 1)
            begin
                if (wr_match && do_write && (wr_idx == i[2:0]))
                    shadow[i] <= merge(shadow[i], wd, ws);
                // plain timer takes values at once
                if (!pwm_en)
                    active[i] <= shadow[i];
                else if (applied[i])
                    active[i] <= shadow[i];
            end
        end
    end

    // ==================================================
    // pwm outputs
    generate
        for (g = 0; g < `N_OUT; g = g + 1)
        begin : pwm_chan
            wire dbl;
            wire ena;
            wire set_e;
            wire clr_e;

            if (g == 0)
            begin : first
                assign dbl = 1'b0;
            end
            else
            begin : later
                assign dbl = pwmctl[`PSEL_LO + g - 1];
            end
            assign ena = pwmctl[`PENA_LO + g];
            // single edge: period sets, own match clears
            // double edge: previous match sets, own match clears
            assign set_e = dbl ? hit[g] : period_evt;
            assign clr_e = hit[g + 1] || (!dbl && period_evt && (active[g + 1] == `RST_WORD));

            always @(posedge clk or negedge rst_s_n)
            begin
                if (!rst_s_n)
                    pwm_out[g] <= 1'b0;
                else if (!pwm_en || !ena)
                    pwm_out[g] <= 1'b0;
                else if (clr_e)
                    pwm_out[g] <= 1'b0;
                // rise at period, or at previous match in double edge, unless width zero
                else if (set_e)
                    pwm_out[g] <= 1'b1;
            end
        end
    endgenerate

    // ==================================================
    // bus read channel
    reg  [31:0] rd_data;
    reg         rd_ok;
    wire [2:0]  rd_idx;

    assign rd_idx = araddr[4:2];

    always @*
    begin
        rd_data = `RST_WORD;
        rd_ok   = 1'b1;
        case (araddr[7:2])
            `A_CTRL >> 2:   rd_data = ctrl;
            `A_COUNT >> 2:  rd_data = count;
            `A_PRESC >> 2:  rd_data = presc;
            `A_PCOUNT >> 2: rd_data = pcount;
            `A_MCTL >> 2:   rd_data = mctl;
            `A_FLAGS >> 2:  rd_data = {25'h0000000, flags};
            `A_PWMCTL >> 2: rd_data = pwmctl;
            `A_LATCH >> 2:  rd_data = {25'h0000000, latch};
            default:
            begin
                if ((araddr[7:5] == 3'h1) && (rd_idx != 3'h7))
                    rd_data = shadow[rd_idx];
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= `RST_WORD;
            rresp   <= `RESP_OK;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_ok ? `RESP_OK : `RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule

// ### tb/pwm_timer_assertions.sv
// port checker of the match based pwm timer
`include "pwm_map.vh"
module pwm_timer_checker (
    input wire logic        clk,     // clock
    input wire logic        rst_n,   // reset
    input wire logic [7:0]  awaddr,  // aw
    input wire logic        awvalid, // aw
    input wire logic        awready, // aw
    input wire logic [31:0] wdata,   // w
    input wire logic [3:0]  wstrb,   // w
    input wire logic        wvalid,  // w
    input wire logic        wready,  // w
    input wire logic [1:0]  bresp,   // b
    input wire logic        bvalid,  // b
    input wire logic        bready,  // b
    input wire logic [7:0]  araddr,  // ar
    input wire logic        arvalid, // ar
    input wire logic        arready, // ar
    input wire logic [31:0] rdata,   // r
    input wire logic [1:0]  rresp,   // r
    input wire logic        rvalid,  // r
    input wire logic        rready,  // r
    input wire logic [5:0]  pwm_out  // outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pwm_mode;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // shadow of the mode bit; assumes address and data are taken together
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            pwm_mode <= 1'b0;
        else if (awvalid && awready && wvalid && wready && awaddr == `A_CTRL && wstrb[0])
            pwm_mode <= wdata[`CTRL_PWM];
    chk_write_answer:
        assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("late write answer");
    chk_read_answer:
        assert property (arvalid && arready |=> rvalid) else $error("late read answer");
    chk_b_holds:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    chk_r_holds:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("read lost");
    chk_one_read:
        assert property (rvalid |-> !arready) else $error("second read accepted");
    chk_one_write:
        assert property (bvalid |-> !awready && !wready) else $error("second write accepted");
    chk_b_done:
        assert property (bvalid && bready |=> !bvalid && awready && wready) else $error("write not closed");
    chk_unmapped_zero:
        assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == `RST_WORD) else $error("error read not 0");
    chk_timer_quiet:
        assert property (!pwm_mode [*3] |-> pwm_out == 6'h00) else $error("output driven in timer mode");
    cover property (bvalid && bready && bresp == `RESP_SLVERR);
    cover property (rvalid && rready && rresp == `RESP_OK);
    cover property ($rose(pwm_out[3]) && pwm_mode);
endmodule

bind match_based_pwm_timer pwm_timer_checker i_pwm_timer_checker (
    .clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pwm_out);

// ### tb/pwm_load_model.sv
// load model: measures high time and period of each output
module pwm_load_model (
    input  wire logic        clk,       // clock
    input  wire logic        clr,       // clear the measurements
    input  wire logic [5:0]  pwm,       // driven outputs
    output logic      [31:0] width [6], // last high time in cycles
    output logic      [31:0] period [6] // last rise to rise time
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] hi [6];
    logic [31:0] pc [6];
    logic [5:0]  last = 6'h00;
    always @(posedge clk)
    begin
        last <= pwm;
        for (int i = 0; i < 6; i++)
        begin
            pc[i] <= pc[i] + 32'h1;
            hi[i] <= hi[i] + 32'(pwm[i]);
            if (pwm[i] && !last[i])
            begin
                period[i] <= pc[i];
                pc[i] <= 32'h1;
                hi[i] <= 32'h1;
            end
            if (!pwm[i] && last[i])
                width[i] <= hi[i];
            if (clr)
            begin
                width[i] <= 32'h0;
                period[i] <= 32'h0;
                pc[i] <= 32'h0;
            end
        end
    end
endmodule

// ### tb/tb_match_based_pwm_timer.sv
// self-checking bench of the match based pwm timer
`include "pwm_map.vh"
module tb_match_based_pwm_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clr = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rdv, c;
    logic [5:0]  pwm_out;
    logic [31:0] width [6], period [6];
    logic [31:0] m [7] = '{32'h9, 32'h3, 32'h7, 32'h6, 32'h1, 32'h0, 32'h0};
    int          n_mismatch = 0;
    int          checks = 0;
    always #10 clk = ~clk;
    match_based_pwm_timer i_match_based_pwm_timer (
        .clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pwm_out);
    pwm_load_model i_pwm_load_model (.clk, .clr, .pwm(pwm_out), .width, .period);
    task end_of_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task guard(inout int n);
        n++;
        if (n > 64)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            guard(n);
            awvalid <= awvalid && awready !== 1'b1;
            wvalid <= wvalid && wready !== 1'b1;
            done = bvalid === 1'b1 && bready;
            bready <= bvalid === 1'b1 && !bready;
        end
        chk(32'(bresp), 32'(er));
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            guard(n);
            arvalid <= arvalid && arready !== 1'b1;
            done = rvalid === 1'b1 && rready;
            rdv = rdata;
            rready <= rvalid === 1'b1 && !rready;
        end
        chk(32'(rresp), 32'(er));
        @(posedge clk);
    endtask
    // settle, then take a fresh measurement of a few periods
    task meas;
        repeat (30) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (35) @(posedge clk);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        clr <= 1'b0;
        repeat (3) @(posedge clk);
        for (int a = 0; a <= 'h38; a += 4)
        begin
            rd(8'(a), `RESP_OK);
            chk(rdv, `RST_WORD);
        end
        rd(8'h3C, `RESP_SLVERR);
        chk(rdv, `RST_WORD);
        wr(8'h3C, 32'h5A, `RESP_SLVERR);
        wr(`A_PRESC, 32'hFFFFFFFF, `RESP_OK);
        wr(`A_CTRL, 32'h1, `RESP_OK);
        repeat (30) @(posedge clk);
        rd(`A_COUNT, `RESP_OK);
        chk(rdv, 32'h0);
        rd(`A_PCOUNT, `RESP_OK);
        chk(32'(rdv != 32'h0), 32'h1);
        wr(`A_CTRL, 32'h3, `RESP_OK);
        wr(`A_PRESC, 32'h1, `RESP_OK);
        wr(`A_MATCH0 + 8'h08, 32'h9, `RESP_OK);
        wr(`A_MCTL, 32'hC0, `RESP_OK);
        wr(`A_CTRL, 32'h1, `RESP_OK);
        repeat (80) @(posedge clk);
        rd(`A_COUNT, `RESP_OK);
        chk(32'(rdv <= 32'h9), 32'h1);
        rd(`A_FLAGS, `RESP_OK);
        chk(rdv, 32'h04);
        wr(`A_CTRL, 32'h3, `RESP_OK);
        wr(`A_FLAGS, 32'h7F, `RESP_OK);
        rd(`A_FLAGS, `RESP_OK);
        chk(rdv, 32'h0);
        rd(`A_PCOUNT, `RESP_OK);
        chk(rdv, 32'h0);
        wr(`A_MATCH0 + 8'h04, 32'h14, `RESP_OK);
        wr(`A_MATCH0 + 8'h0C, 32'h5, `RESP_OK);
        wr(`A_MCTL, 32'h228, `RESP_OK);
        wr(`A_PRESC, 32'h0, `RESP_OK);
        wr(`A_CTRL, 32'h1, `RESP_OK);
        repeat (60) @(posedge clk);
        rd(`A_CTRL, `RESP_OK);
        chk(rdv, 32'h0);
        rd(`A_COUNT, `RESP_OK);
        c = rdv;
        chk(32'(c >= 32'h14 && c <= 32'h15), 32'h1);
        rd(`A_COUNT, `RESP_OK);
        chk(rdv, c);
        rd(`A_FLAGS, `RESP_OK);
        chk(rdv, 32'h0A);
        wr(`A_CTRL, 32'h2, `RESP_OK);
        wr(`A_MCTL, 32'h0, `RESP_OK);
        for (int i = 0; i < 7; i++)
            wr(`A_MATCH0 + 8'(4 * i), m[i], `RESP_OK);
        wr(`A_PWMCTL, 32'h5614, `RESP_OK);
        wr(`A_CTRL, 32'h9, `RESP_OK);
        meas();
        chk(period[0], m[0] + 32'h1);
        chk(period[3], m[0] + 32'h1);
        chk(width[0], m[1] + 32'h1);
        chk(width[1], m[2] - m[1]);
        chk(width[3], m[0] + 32'h1 - m[3] + m[4]);
        chk(width[5], 32'h0);
        chk(width[2] + width[4], 32'h0);
        wr(`A_MATCH0 + 8'h04, 32'h5, `RESP_OK);
        meas();
        chk(width[0], m[1] + 32'h1);
        wr(`A_LATCH, 32'h02, `RESP_OK);
        meas();
        chk(width[0], 32'h6);
        chk(width[1], m[2] - 32'h5);
        rd(`A_LATCH, `RESP_OK);
        chk(rdv, 32'h0);
        wr(`A_CTRL, 32'h1, `RESP_OK);
        repeat (4) @(posedge clk);
        chk(32'(pwm_out), 32'h0);
        end_of_test();
    end
endmodule
